/* File: inc/ilo_pkg.sv */
package ilo_pkg;

   //----------------------------------------------------------------------
   // widths
   //----------------------------------------------------------------------
   localparam int ILO_DADDR_W = 12;
   localparam int ILO_BANK_W = 4;
   localparam int ILO_AXI_AW = 8;

   //----------------------------------------------------------------------
   // register byte offsets
   //----------------------------------------------------------------------
   localparam logic [7:0] ILO_OFS_CTRL = 8'h00;
   localparam logic [7:0] ILO_OFS_PTR = 8'h04;
   localparam logic [7:0] ILO_OFS_WACC = 8'h08;
   localparam logic [7:0] ILO_OFS_BANK = 8'h0c;
   localparam logic [7:0] ILO_OFS_FLAGS = 8'h10;
   localparam logic [7:0] ILO_OFS_INSTR = 8'h14;
   localparam logic [7:0] ILO_OFS_XSTAT = 8'h18;

   //----------------------------------------------------------------------
   // field positions
   //----------------------------------------------------------------------
   localparam int ILO_CTRL_EXT_BIT = 0;
   localparam int ILO_FLG_C = 0;
   localparam int ILO_FLG_DC = 1;
   localparam int ILO_FLG_Z = 2;
   localparam int ILO_FLG_OV = 3;
   localparam int ILO_FLG_N = 4;
   localparam int ILO_XST_BUSY = 0;
   localparam int ILO_XST_ILLEGAL = 1;
   localparam int ILO_XST_INDEXED = 2;
   localparam int ILO_XST_ADDR_LSB = 16;
   localparam int ILO_INS_A_BIT = 8;
   localparam int ILO_INS_D_BIT = 9;
   localparam int ILO_INS_B_LSB = 9;

   //----------------------------------------------------------------------
   // reset values
   //----------------------------------------------------------------------
   localparam logic ILO_EXT_RST = 1'b0;
   localparam logic [ILO_DADDR_W-1:0] ILO_PTR_RST = 12'h000;
   localparam logic [7:0] ILO_WACC_RST = 8'h00;
   localparam logic [ILO_BANK_W-1:0] ILO_BANK_RST = 4'h0;
   localparam logic [4:0] ILO_FLAGS_RST = 5'h00;

   //----------------------------------------------------------------------
   // opcodes, operand limits, bus answers
   //----------------------------------------------------------------------
   localparam logic [5:0] ILO_OPC_ADD = 6'h09;
   localparam logic [3:0] ILO_OPC_BSET = 4'h8;
   localparam logic [6:0] ILO_OPC_SETALL = 7'h34;
   localparam logic [7:0] ILO_IDX_MAX = 8'h5f;
   localparam logic [7:0] ILO_SET_ALL = 8'hff;
   localparam logic [1:0] ILO_RESP_OKAY = 2'h0;
   localparam logic [1:0] ILO_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ILO_IDLE = 3'h0,
      ILO_DECODE = 3'h1,
      ILO_READ = 3'h3,
      ILO_PROC = 3'h2,
      ILO_WRITE = 3'h6
   } ilo_state_e;

   typedef enum logic [1:0] {
      ILO_OP_NONE = 2'h0,
      ILO_OP_ADD = 2'h1,
      ILO_OP_BSET = 2'h2,
      ILO_OP_SETALL = 2'h3
   } ilo_op_e;

endpackage

/* File: hdl/ilo_addr_gen.sv */
`timescale 1ns/100ps
module ilo_addr_gen
   import ilo_pkg::*;
#(
   parameter int DADDR_W = ILO_DADDR_W,
   parameter int BANK_W = ILO_BANK_W
) (
   input wire logic ext_en,
   input wire logic bank_acc,
   input wire logic [7:0] operand,
   input wire logic [DADDR_W-1:0] base_ptr,
   input wire logic [BANK_W-1:0] bank_sel,
   output logic [DADDR_W-1:0] eff_addr,
   output logic indexed
);

   //----------------------------------------------------------------------
   // effective data address
   //----------------------------------------------------------------------
   // indexed only with extension on, access bit clear and a low operand
   assign indexed = ext_en && !bank_acc && (operand <= ILO_IDX_MAX);

   // pointer itself is never written here, only read
   always_comb begin
      if (indexed) begin
         eff_addr = base_ptr + DADDR_W'(operand);
      end else if (bank_acc) begin
         eff_addr = DADDR_W'({bank_sel, operand});
      end else if (operand <= ILO_IDX_MAX) begin
         eff_addr = DADDR_W'(operand);
      end else begin
         // upper part of the quick-access bank sits at the top of data space
         eff_addr = {{(DADDR_W-8){1'b1}}, operand};
      end
   end

endmodule

/* File: hdl/ilo_alu.sv */
`timescale 1ns/100ps
module ilo_alu
   import ilo_pkg::*;
(
   input wire ilo_op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem,
   input wire logic [2:0] bit_sel,
   input wire logic [4:0] flags_in,
   output logic [7:0] result,
   output logic [4:0] flags_out
);

   //----------------------------------------------------------------------
   // datapath
   //----------------------------------------------------------------------
   logic [8:0] sum;
   logic [4:0] low_sum;

   assign sum = {1'b0, acc} + {1'b0, mem};
   assign low_sum = {1'b0, acc[3:0]} + {1'b0, mem[3:0]};

   // only the add touches flags; bit-set and set-all pass them through
   always_comb begin
      result = mem;
      flags_out = flags_in;
      unique case (op)
         ILO_OP_ADD: begin
            result = sum[7:0];
            flags_out[ILO_FLG_C] = sum[8];
            flags_out[ILO_FLG_DC] = low_sum[4];
            flags_out[ILO_FLG_Z] = (sum[7:0] == 8'h00);
            flags_out[ILO_FLG_N] = sum[7];
            flags_out[ILO_FLG_OV] = (acc[7] == mem[7]) && (sum[7] != acc[7]);
         end
         ILO_OP_BSET: begin
            result = mem | (8'h01 << bit_sel);
         end
         ILO_OP_SETALL: begin
            result = ILO_SET_ALL;
         end
         ILO_OP_NONE: begin
            result = mem;
         end
      endcase
   end

endmodule

/* File: hdl/ilo_exec.sv */
`timescale 1ns/100ps
module ilo_exec
   import ilo_pkg::*;
#(
   parameter int DADDR_W = ILO_DADDR_W,
   parameter int BANK_W = ILO_BANK_W
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [ILO_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ILO_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [DADDR_W-1:0] DMEM_ADDR,
   output logic DMEM_RE,
   output logic DMEM_WE,
   output logic [7:0] DMEM_WDATA,
   input wire logic [7:0] DMEM_RDATA
);

   //----------------------------------------------------------------------
   // state
   //----------------------------------------------------------------------
   typedef struct packed {
      logic aw_held;
      logic [ILO_AXI_AW-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic ext_en;
      logic [DADDR_W-1:0] ptr;
      logic [7:0] wacc;
      logic [BANK_W-1:0] bank_select_register;
      logic [4:0] flags;
      logic [15:0] instr;
      ilo_state_e st;
      ilo_op_e op;
      logic illegal;
      logic indexed;
      logic [DADDR_W-1:0] addr;
      logic re;
      logic we;
      logic [7:0] wdata;
   } ilo_exec_s;

   localparam ilo_exec_s EXEC_RST = '{
      ext_en: ILO_EXT_RST,
      ptr: ILO_PTR_RST,
      wacc: ILO_WACC_RST,
      bank_select_register: ILO_BANK_RST,
      flags: ILO_FLAGS_RST,
      st: ILO_IDLE,
      op: ILO_OP_NONE,
      default: '0
   };

   ilo_exec_s s_reg;
   ilo_exec_s s_next;

   logic [DADDR_W-1:0] ag_addr;
   logic ag_indexed;
   logic [7:0] alu_result;
   logic [4:0] alu_flags;
   logic [31:0] wr_merged;
   logic [31:0] wr_old;
   logic [7:0] wr_word;
   logic [7:0] rd_word;
   logic busy;

   //----------------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------------
   // byte lanes not strobed keep their old contents
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_val[8*i +: 8];
         end
      end
      return res;
   endfunction

   // one program word selects one of the three operations or none
   function automatic ilo_op_e decode_op(input logic [15:0] ins);
      ilo_op_e op;
      op = ILO_OP_NONE;
      if (ins[15:10] == ILO_OPC_ADD) begin
         op = ILO_OP_ADD;
      end else if (ins[15:12] == ILO_OPC_BSET) begin
         op = ILO_OP_BSET;
      end else if (ins[15:9] == ILO_OPC_SETALL) begin
         op = ILO_OP_SETALL;
      end
      return op;
   endfunction

   // readable view of every register at a word-aligned offset
   function automatic logic [31:0] reg_view(input ilo_exec_s s, input logic [7:0] ofs);
      logic [31:0] v;
      v = '0;
      unique case (ofs)
         ILO_OFS_CTRL: v[ILO_CTRL_EXT_BIT] = s.ext_en;
         ILO_OFS_PTR: v[DADDR_W-1:0] = s.ptr;
         ILO_OFS_WACC: v[7:0] = s.wacc;
         ILO_OFS_BANK: v[BANK_W-1:0] = s.bank_select_register;
         ILO_OFS_FLAGS: v[4:0] = s.flags;
         ILO_OFS_INSTR: v[15:0] = s.instr;
         ILO_OFS_XSTAT: begin
            v[ILO_XST_BUSY] = (s.st != ILO_IDLE);
            v[ILO_XST_ILLEGAL] = s.illegal;
            v[ILO_XST_INDEXED] = s.indexed;
            v[ILO_XST_ADDR_LSB +: 16] = 16'(s.addr);
         end
         default: v = '0;
      endcase
      return v;
   endfunction

   // offsets that answer OKAY; anything else gets SLVERR
   function automatic logic is_mapped(input logic [7:0] ofs);
      return (ofs == ILO_OFS_CTRL) || (ofs == ILO_OFS_PTR) || (ofs == ILO_OFS_WACC)
         || (ofs == ILO_OFS_BANK) || (ofs == ILO_OFS_FLAGS) || (ofs == ILO_OFS_INSTR)
         || (ofs == ILO_OFS_XSTAT);
   endfunction

   //----------------------------------------------------------------------
   // address generation and arithmetic
   //----------------------------------------------------------------------
   ilo_addr_gen #(
      .DADDR_W(DADDR_W),
      .BANK_W(BANK_W)
   ) u_addr_gen (
      .ext_en(s_reg.ext_en),
      .bank_acc(s_reg.instr[ILO_INS_A_BIT]),
      .operand(s_reg.instr[7:0]),
      .base_ptr(s_reg.ptr),
      .bank_sel(s_reg.bank_select_register),
      .eff_addr(ag_addr),
      .indexed(ag_indexed)
   );

   ilo_alu u_alu (
      .op(s_reg.op),
      .acc(s_reg.wacc),
      .mem(DMEM_RDATA),
      .bit_sel(s_reg.instr[ILO_INS_B_LSB +: 3]),
      .flags_in(s_reg.flags),
      .result(alu_result),
      .flags_out(alu_flags)
   );

   //----------------------------------------------------------------------
   // next state
   //----------------------------------------------------------------------
   assign busy = (s_reg.st != ILO_IDLE);
   assign wr_word = {s_reg.aw_addr[7:2], 2'b00};
   assign rd_word = {S_AXI_ARADDR[7:2], 2'b00};
   assign wr_old = reg_view(s_reg, wr_word);
   assign wr_merged = merge_lanes(wr_old, s_reg.w_data, s_reg.w_strb);

   always_comb begin
      s_next = s_reg;

      // execution: decode, read operand, process, write destination
      unique case (s_reg.st)
         ILO_IDLE: begin
            s_next.re = 1'b0;
            s_next.we = 1'b0;
         end
         ILO_DECODE: begin
            s_next.op = decode_op(s_reg.instr);
            s_next.illegal = (decode_op(s_reg.instr) == ILO_OP_NONE);
            s_next.addr = ag_addr;
            s_next.indexed = ag_indexed;
            // set-all has nothing to fetch, so the read strobe stays low
            s_next.re = (decode_op(s_reg.instr) == ILO_OP_ADD)
               || (decode_op(s_reg.instr) == ILO_OP_BSET);
            if (decode_op(s_reg.instr) == ILO_OP_NONE) begin
               s_next.st = ILO_IDLE;
            end else begin
               s_next.st = ILO_READ;
            end
         end
         ILO_READ: begin
            s_next.re = 1'b0;
            s_next.st = ILO_PROC;
         end
         ILO_PROC: begin
            s_next.wdata = alu_result;
            s_next.flags = alu_flags;
            if (s_reg.op == ILO_OP_ADD && !s_reg.instr[ILO_INS_D_BIT]) begin
               s_next.wacc = alu_result;
               s_next.we = 1'b0;
            end else begin
               s_next.we = 1'b1;
            end
            s_next.st = ILO_WRITE;
         end
         ILO_WRITE: begin
            s_next.we = 1'b0;
            s_next.st = ILO_IDLE;
         end
      endcase

      // write address and data are taken independently, in either order
      if (S_AXI_AWVALID && !s_reg.aw_held && !s_reg.bvalid) begin
         s_next.aw_held = 1'b1;
         s_next.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !s_reg.w_held && !s_reg.bvalid) begin
         s_next.w_held = 1'b1;
         s_next.w_data = S_AXI_WDATA;
         s_next.w_strb = S_AXI_WSTRB;
      end
      if (s_reg.bvalid && S_AXI_BREADY) begin
         s_next.bvalid = 1'b0;
      end

      // register update once both halves are in; while an operation runs
      // software writes are dropped so the core never sees a torn state
      if (s_reg.aw_held && s_reg.w_held) begin
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = is_mapped(wr_word) ? ILO_RESP_OKAY : ILO_RESP_SLVERR;
         if (!busy) begin
            unique case (wr_word)
               ILO_OFS_CTRL: s_next.ext_en = wr_merged[ILO_CTRL_EXT_BIT];
               ILO_OFS_PTR: s_next.ptr = wr_merged[DADDR_W-1:0];
               ILO_OFS_WACC: s_next.wacc = wr_merged[7:0];
               ILO_OFS_BANK: s_next.bank_select_register = wr_merged[BANK_W-1:0];
               ILO_OFS_FLAGS: s_next.flags = wr_merged[4:0];
               ILO_OFS_INSTR: begin
                  s_next.instr = wr_merged[15:0];
                  if (|s_reg.w_strb[1:0]) begin
                     s_next.st = ILO_DECODE;
                  end
               end
               default: s_next.bresp = s_next.bresp;
            endcase
         end
      end

      // reads answer one edge after the address is taken
      if (s_reg.rvalid && S_AXI_RREADY) begin
         s_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && !s_reg.rvalid) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = reg_view(s_reg, rd_word);
         s_next.rresp = is_mapped(rd_word) ? ILO_RESP_OKAY : ILO_RESP_SLVERR;
      end
   end

   //----------------------------------------------------------------------
   // state register
   //----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_reg <= EXEC_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   //----------------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------------
   // ready terms are combinational; everything else comes from flops
   assign S_AXI_AWREADY = !s_reg.aw_held && !s_reg.bvalid;
   assign S_AXI_WREADY = !s_reg.w_held && !s_reg.bvalid;
   assign S_AXI_BVALID = s_reg.bvalid;
   assign S_AXI_BRESP = s_reg.bresp;
   assign S_AXI_ARREADY = !s_reg.rvalid;
   assign S_AXI_RVALID = s_reg.rvalid;
   assign S_AXI_RDATA = s_reg.rdata;
   assign S_AXI_RRESP = s_reg.rresp;

   // memory port: one-cycle read latency expected from the data memory
   assign DMEM_ADDR = s_reg.addr;
   assign DMEM_RE = s_reg.re;
   assign DMEM_WE = s_reg.we;
   assign DMEM_WDATA = s_reg.wdata;

endmodule

/* File: tb/ilo_exec_properties.sv */
`timescale 1ns/100ps
module ilo_exec_properties
   import ilo_pkg::*;
#(
   parameter int DADDR_W = ILO_DADDR_W
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [DADDR_W-1:0] DMEM_ADDR,
   input wire logic DMEM_RE,
   input wire logic DMEM_WE,
   input wire logic [7:0] DMEM_WDATA
);
   //----------------------------------------------------------------
   // one clock domain, so one default clocking
   //----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   // memory strobes and address over the four phases
   re_one_cycle_a: assert property (DMEM_RE |=> !DMEM_RE)
      else $error("read strobe longer than one cycle");
   we_one_cycle_a: assert property (DMEM_WE |=> !DMEM_WE)
      else $error("write strobe longer than one cycle");
   addr_hold_a: assert property (DMEM_RE |=> $stable(DMEM_ADDR) [*2])
      else $error("data address moved during operation");
   // a write without a read two cycles before can only be set-all
   setall_data_a: assert property (DMEM_WE && !$past(DMEM_RE, 2) |-> DMEM_WDATA == ILO_SET_ALL)
      else $error("set-all wrote other than all ones");

   // register bus answers
   // both halves taken at one edge, register updated at the next, answer seen one later
   bresp_after_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   rdata_after_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   wr_blocked_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while answer pending");

   c_read_op: cover property (DMEM_RE ##2 DMEM_WE);
   c_setall: cover property (DMEM_WE && DMEM_WDATA == ILO_SET_ALL);
   c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == ILO_RESP_SLVERR);
endmodule

/* File: tb/ilo_mem_model.sv */
`timescale 1ns/100ps
module ilo_mem_model #(
   parameter int AW = 12
) (
   input wire logic clk,
   input wire logic [AW-1:0] addr,
   input wire logic re,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [2**AW];

   initial begin
      rdata = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
   end

   // one-cycle synchronous read; outside it the bus toggles so nothing stale passes
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule

/* File: tb/ilo_exec_test.sv */
`timescale 1ns/100ps
module ilo_exec_test
   import ilo_pkg::*;
;
   logic CORE_CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] S_AXI_AWADDR = 8'h00;
   logic S_AXI_AWVALID = 1'b0;
   logic S_AXI_AWREADY;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic S_AXI_WVALID = 1'b0;
   logic S_AXI_WREADY;
   logic [1:0] S_AXI_BRESP;
   logic S_AXI_BVALID;
   logic S_AXI_BREADY = 1'b0;
   logic [7:0] S_AXI_ARADDR = 8'h00;
   logic S_AXI_ARVALID = 1'b0;
   logic S_AXI_ARREADY;
   logic [31:0] S_AXI_RDATA;
   logic [1:0] S_AXI_RRESP;
   logic S_AXI_RVALID;
   logic S_AXI_RREADY = 1'b0;
   logic [11:0] DMEM_ADDR;
   logic DMEM_RE;
   logic DMEM_WE;
   logic [7:0] DMEM_WDATA;
   logic [7:0] DMEM_RDATA;
   int num_errors = 0;
   int total_checks = 0;
   logic [1:0] resp;
   logic [31:0] rd;

   ilo_exec i_dut (.*);
   ilo_mem_model #(.AW(12)) i_mem (
      .clk(CORE_CLK),
      .addr(DMEM_ADDR),
      .re(DMEM_RE),
      .we(DMEM_WE),
      .wdata(DMEM_WDATA),
      .rdata(DMEM_RDATA)
   );

   initial begin
      forever #2.5 CORE_CLK = ~CORE_CLK;
   end

   //----------------------------------------------------------------
   // bus tasks; each starts and ends just after a rising edge
   //----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      S_AXI_AWADDR <= a;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WDATA <= d;
      S_AXI_WVALID <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge CORE_CLK);
         if (!aw_ok && S_AXI_AWREADY === 1'b1) begin
            aw_ok = 1'b1;
            S_AXI_AWVALID <= 1'b0;
         end
         if (!w_ok && S_AXI_WREADY === 1'b1) begin
            w_ok = 1'b1;
            S_AXI_WVALID <= 1'b0;
         end
      end
      // late bready: one edge sees the answer standing with bready low
      repeat (2) @(posedge CORE_CLK);
      S_AXI_BREADY <= 1'b1;
      do
         @(posedge CORE_CLK);
      while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      resp = S_AXI_BRESP;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do
         @(posedge CORE_CLK);
      while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      @(posedge CORE_CLK);
      S_AXI_RREADY <= 1'b1;
      do
         @(posedge CORE_CLK);
      while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      rd = S_AXI_RDATA;
      resp = S_AXI_RRESP;
   endtask

   // launch an opcode and poll status until idle; rd keeps the status
   task automatic op_at(input logic [15:0] ins, input logic [11:0] ea, input logic idx);
      int n;
      wr(ILO_OFS_INSTR, {16'h0, ins});
      check("launch resp", 32'(resp), 32'(ILO_RESP_OKAY));
      n = 0;
      do begin
         rd_reg(ILO_OFS_XSTAT);
         n++;
      end while (rd[ILO_XST_BUSY] !== 1'b0 && n < 10);
      check("op done", 32'(rd[ILO_XST_BUSY]), 32'h0);
      check("eff addr", 32'(rd[27:16]), 32'(ea));
      check("indexed", 32'(rd[ILO_XST_INDEXED]), 32'(idx));
   endtask

   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] ofs [5] = '{ILO_OFS_CTRL, ILO_OFS_PTR, ILO_OFS_WACC, ILO_OFS_BANK, ILO_OFS_FLAGS};
      foreach (ofs[i]) begin
         rd_reg(ofs[i]);
         check("reset value", rd, 32'h0);
      end
      rd_reg(8'h40);
      check("unmapped rd", 32'(resp), 32'(ILO_RESP_SLVERR));
      wr(8'h40, 32'h1);
      check("unmapped wr", 32'(resp), 32'(ILO_RESP_SLVERR));
      // only the low lane strobed: upper pointer bits keep their reset zero
      S_AXI_WSTRB <= 4'h1;
      wr(ILO_OFS_PTR, 32'h0000_0abc);
      S_AXI_WSTRB <= 4'hf;
      rd_reg(ILO_OFS_PTR);
      check("lane merge", rd, 32'h0bc);
      $display("t_reset done");
   endtask

   task automatic t_add;
      logic [7:0] acc [4] = '{8'h17, 8'h7f, 8'hff, 8'h80};
      logic [7:0] opd [4] = '{8'h20, 8'h01, 8'h01, 8'h80};
      logic [4:0] flg [4] = '{5'h00, 5'h1a, 5'h07, 5'h0d};
      wr(ILO_OFS_CTRL, 32'h1);
      wr(ILO_OFS_PTR, 32'ha00);
      i_mem.mem[12'ha2c] = 8'h20;
      wr(ILO_OFS_WACC, 32'h17);
      op_at(16'h242c, 12'ha2c, 1'b1);
      rd_reg(ILO_OFS_WACC);
      check("add to acc", rd, 32'h37);
      check("mem kept", 32'(i_mem.mem[12'ha2c]), 32'h20);
      op_at(16'h262c, 12'ha2c, 1'b1);
      check("add to mem", 32'(i_mem.mem[12'ha2c]), 32'h57);
      foreach (acc[i]) begin
         wr(ILO_OFS_WACC, 32'(acc[i]));
         i_mem.mem[12'ha10] = opd[i];
         op_at(16'h2410, 12'ha10, 1'b1);
         rd_reg(ILO_OFS_FLAGS);
         check("add flags", rd, 32'(flg[i]));
      end
      $display("t_add done");
   endtask

   task automatic t_set_ops;
      wr(ILO_OFS_FLAGS, 32'h15);
      i_mem.mem[12'ha0a] = 8'h00;
      for (int b = 0; b < 8; b++) begin
         op_at({4'h8, 3'(b), 1'b0, 8'h0a}, 12'ha0a, 1'b1);
         check("bit set", 32'(i_mem.mem[12'ha0a]), (32'h2 << b) - 1);
      end
      op_at(16'h682c, 12'ha2c, 1'b1);
      check("set all", 32'(i_mem.mem[12'ha2c]), 32'hff);
      rd_reg(ILO_OFS_FLAGS);
      check("flags kept", rd, 32'h15);
      $display("t_set_ops done");
   endtask

   task automatic t_modes;
      wr(ILO_OFS_PTR, 32'hff0);
      wr(ILO_OFS_BANK, 32'h3);
      op_at(16'h685f, 12'h04f, 1'b1);
      op_at(16'h6860, 12'hf60, 1'b0);
      op_at(16'h6910, 12'h310, 1'b0);
      wr(ILO_OFS_CTRL, 32'h0);
      op_at(16'h6810, 12'h010, 1'b0);
      op_at(16'h6910, 12'h310, 1'b0);
      check("literal write", 32'(i_mem.mem[12'h010]), 32'hff);
      wr(ILO_OFS_INSTR, 32'hf000);
      rd_reg(ILO_OFS_XSTAT);
      check("illegal", 32'(rd[ILO_XST_ILLEGAL]), 32'h1);
      $display("t_modes done");
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a hung handshake would otherwise stall the run forever
   initial begin
      #200000;
      num_errors++;
      close_out;
   end

   initial begin
      repeat (12) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      @(posedge CORE_CLK);
      t_reset;
      t_add;
      t_set_ops;
      t_modes;
      close_out;
   end
endmodule

bind ilo_exec ilo_exec_properties #(.DADDR_W(DADDR_W)) i_props (.*);
